/* File: verilog/enc_decoder.sv */
// decoder end: quadrature counter, pulse-width capture, loss detect
`timescale 1ns/1ns
`default_nettype none
module enc_decoder
   import enc_pkg::*;
#(
   parameter int LOSS_CYCLES = LOSS_CYC
) (
   input wire logic clock, // 25 MHz clock
   input wire logic rst_b, // synchronous reset, active low
   input wire logic seed_req, // load count from absolute angle
   enc_link_if.decoder link, // lines from the sensor
   output logic [31:0] quad_count, // relative quadrature count
   output logic [ANGLE_W-1:0] abs_angle, // last decoded absolute angle
   output logic abs_valid, // a full pulse has been decoded
   output logic sensor_lost, // no pulse for too long
   output logic seeded // count loaded from absolute angle
);
   logic [1:0] ab_ff, nxt_ab;
   logic [31:0] cnt_ff, nxt_cnt;
   logic pw_ff, nxt_pw;
   logic [CNT_W-1:0] hcnt_ff, nxt_hcnt, idle_ff, nxt_idle;
   logic [ANGLE_W-1:0] ang_ff, nxt_ang;
   logic val_ff, nxt_val, lost_ff, nxt_lost, done_ff;
   logic pw_fall;
   seed_state_t seed_ff, nxt_seed;

   // decode one gray step: +1, -1 or 0
   function automatic logic [1:0] step(input logic [1:0] p, n);
      logic [1:0] pg, ng;
      pg = {p[1], p[1] ^ p[0]};
      ng = {n[1], n[1] ^ n[0]};
      if (ng == pg + 2'd1) step = 2'b01;
      else if (ng == pg - 2'd1) step = 2'b11;
      else step = 2'b00;
   endfunction

   // quadrature count and seed sequence
   always_comb begin
      nxt_ab = {link.quad_a, link.quad_b};
      nxt_cnt = cnt_ff;
      nxt_seed = seed_ff;
      case (step(ab_ff, nxt_ab))
         2'b01: nxt_cnt = cnt_ff + 32'd1;
         2'b11: nxt_cnt = cnt_ff - 32'd1;
         default: nxt_cnt = cnt_ff;
      endcase
      case (seed_ff)
         SEED_IDLE: if (seed_req) nxt_seed = SEED_WAIT;
         // wait for the next pulse to end, then load its decoded angle
         SEED_WAIT: if (pw_fall) begin
            nxt_cnt = 32'(nxt_ang);
            nxt_seed = SEED_DONE;
         end
         SEED_DONE: if (seed_req) nxt_seed = SEED_WAIT;
         default: nxt_seed = SEED_IDLE;
      endcase
   end

   // pulse width measure; value only known once pulse ends
   always_comb begin
      nxt_pw = link.pw_out;
      pw_fall = pw_ff && !link.pw_out;
      nxt_hcnt = link.pw_out ? hcnt_ff + 1'b1 : '0;
      nxt_ang = ang_ff;
      nxt_val = val_ff;
      // idle count freezes once lost so it never wraps back to quiet
      nxt_idle = pw_fall ? '0 : (lost_ff ? idle_ff : idle_ff + 1'b1);
      nxt_lost = lost_ff;
      if (pw_fall) begin
         nxt_ang = ANGLE_W'((hcnt_ff + 1'b1 - CNT_W'(MIN_HIGH_CYC)
            + CNT_W'(STEP_CYC / 2)) / CNT_W'(STEP_CYC));
         nxt_val = 1'b1;
         nxt_lost = 1'b0;
      end else if (idle_ff >= CNT_W'(LOSS_CYCLES)) begin
         nxt_lost = 1'b1;
         nxt_val = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ab_ff <= 2'b00;
         cnt_ff <= '0;
         pw_ff <= 1'b0;
         hcnt_ff <= '0;
         idle_ff <= '0;
         ang_ff <= '0;
         val_ff <= 1'b0;
         lost_ff <= 1'b0;
         seed_ff <= SEED_IDLE;
         done_ff <= 1'b0;
      end else begin
         ab_ff <= nxt_ab;
         cnt_ff <= nxt_cnt;
         pw_ff <= nxt_pw;
         hcnt_ff <= nxt_hcnt;
         idle_ff <= nxt_idle;
         ang_ff <= nxt_ang;
         val_ff <= nxt_val;
         lost_ff <= nxt_lost;
         seed_ff <= nxt_seed;
         done_ff <= (nxt_seed == SEED_DONE);
      end
   end

   assign quad_count = cnt_ff;
   assign abs_angle = ang_ff;
   assign abs_valid = val_ff;
   assign sensor_lost = lost_ff;
   assign seeded = done_ff;
endmodule
`default_nettype wire

/* File: verilog/enc_pkg.sv */
// shared constants for the dual output position encoder link
package enc_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_NS = 40;
   localparam int COUNTS_PER_REV = 1024;
   localparam int ANGLE_W = 10;
   // pulse-width frame period in microseconds, nominally 4 ms
   localparam int FRAME_US = 4000;
   localparam int FRAME_CYC = (FRAME_US * 1000) / CLK_NS;
   // high time per angle step, low floor so a zero angle still pulses
   localparam int STEP_CYC = 80;
   localparam int MIN_HIGH_CYC = 25;
   // decoder gives up after this many frames without a pulse
   localparam int LOSS_FRAMES = 3;
   localparam int LOSS_CYC = FRAME_CYC * LOSS_FRAMES;
   localparam int CNT_W = 24;
   localparam logic [1:0] PHASE_RESET = 2'b00;
   typedef enum logic [1:0] {
      PW_LOW = 2'b00,
      PW_HIGH = 2'b01
   } pw_state_t;
   typedef enum logic [1:0] {
      SEED_IDLE = 2'b00,
      SEED_WAIT = 2'b01,
      SEED_DONE = 2'b10
   } seed_state_t;
endpackage

/* File: verilog/enc_link_if.sv */
// link between the encoder and its decoder: two quadrature lines, one pulse
`timescale 1ns/1ns
`default_nettype none
interface enc_link_if;
   logic quad_a; // quadrature phase a
   logic quad_b; // quadrature phase b
   logic pw_out; // absolute angle pulse
   modport sensor (output quad_a, output quad_b, output pw_out);
   modport decoder (input quad_a, input quad_b, input pw_out);
endinterface
`default_nettype wire

/* File: verilog/enc_sensor.sv */
// sensor end: quadrature and pulse-width outputs from a shaft angle
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - drive pulse width and quadrature together
// - 1024 counts per mechanical revolution
// - quadrature count relative to power-up angle
// - one edge per position step, one step per clock cycle
// - pulse width encodes absolute angle
// - pulse width refreshes every ~4 ms
// - decoder tolerates 4 ms pulse latency
// - pulses continue at rest and any speed
// - decoder flags missing pulses as unplugged
// - fast speed: use quadrature for velocity
// - slow speed: either output, may compare
// - seed quadrature count from resting pulse
// - absolute angle needs pulse-width decode
module enc_sensor
   import enc_pkg::*;
#(
   parameter int FRAME_CYCLES = FRAME_CYC
) (
   input wire logic clock, // 25 MHz clock
   input wire logic rst_b, // synchronous reset, active low
   input wire logic [ANGLE_W-1:0] angle, // measured magnet angle
   enc_link_if.sensor link // outputs to the decoder
);
   logic [ANGLE_W-1:0] last_ff, nxt_last;
   logic [1:0] phase_ff, nxt_phase;
   logic a_ff, nxt_a, b_ff, nxt_b, pw_ff, nxt_pw;
   logic [CNT_W-1:0] fcnt_ff, nxt_fcnt;
   logic [CNT_W-1:0] high_ff, nxt_high;
   logic [ANGLE_W-1:0] diff;

   // quadrature: walk one gray step per angle step toward the target
   always_comb begin
      nxt_last = last_ff;
      nxt_phase = phase_ff;
      diff = angle - last_ff;
      if (diff != '0) begin
         if (diff[ANGLE_W-1]) begin // backwards, shortest way round
            nxt_last = last_ff - 1'b1;
            nxt_phase = phase_ff - 2'd1;
         end else begin
            nxt_last = last_ff + 1'b1;
            nxt_phase = phase_ff + 2'd1;
         end
      end
      // gray code of the phase gives one edge per step
      nxt_a = nxt_phase[1];
      nxt_b = nxt_phase[1] ^ nxt_phase[0];
   end

   // pulse width: free-running frame, high time tracks angle
   always_comb begin
      nxt_pw = pw_ff;
      nxt_high = high_ff;
      nxt_fcnt = fcnt_ff + 1'b1;
      if (fcnt_ff >= CNT_W'(FRAME_CYCLES - 1)) begin
         nxt_fcnt = '0;
         // latch angle at frame start; runs even when shaft is still
         nxt_high = CNT_W'(MIN_HIGH_CYC)
            + CNT_W'(angle) * CNT_W'(STEP_CYC);
         nxt_pw = 1'b1;
      end else if (fcnt_ff + 1'b1 >= high_ff) begin
         nxt_pw = 1'b0;
      end
   end

   // registers; power-up angle becomes quadrature zero
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         // tracker follows the live angle, so release angle is count zero
         last_ff <= angle;
         phase_ff <= PHASE_RESET;
         a_ff <= 1'b0;
         b_ff <= 1'b0;
         pw_ff <= 1'b0;
         fcnt_ff <= '0;
         high_ff <= '0;
      end else begin
         last_ff <= nxt_last;
         phase_ff <= nxt_phase;
         a_ff <= nxt_a;
         b_ff <= nxt_b;
         pw_ff <= nxt_pw;
         fcnt_ff <= nxt_fcnt;
         high_ff <= nxt_high;
      end
   end

   // both outputs driven every cycle, straight from flops
   assign link.quad_a = a_ff;
   assign link.quad_b = b_ff;
   assign link.pw_out = pw_ff;
endmodule
`default_nettype wire

/* File: dv/enc_link_props.sv */
// assertions on the encoder link wires
`timescale 1ns/1ns
`default_nettype none
module enc_link_props #(
   parameter int FRAMEP = 2000
) (
   input wire logic clock, // link clock
   input wire logic rst_b, // sensor reset, active low
   input wire logic quad_a, // phase a
   input wire logic quad_b, // phase b
   input wire logic pw_out // angle pulse
);
   int gap_ff; // cycles since the last pulse rise
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // counter restarts on each rise, so a stalled frame shows up
   always_ff @(posedge clock) begin
      gap_ff <= (!rst_b || $rose(pw_out)) ? 0 : gap_ff + 1;
   end
   AST_GRAY: assert property (!($changed(quad_a) && $changed(quad_b)))
      else $error("both phases moved at once");
   AST_QUAD_RST: assert property (disable iff (1'b0)
      !rst_b |=> !quad_a && !quad_b) else $error("phases not zero in reset");
   AST_PW_RST: assert property (disable iff (1'b0)
      !rst_b |=> !pw_out) else $error("pulse high in reset");
   AST_PW_MIN: assert property ($rose(pw_out) |-> pw_out[*8])
      else $error("pulse too short");
   AST_PW_GAP: assert property ($fell(pw_out) |-> !pw_out[*8])
      else $error("gap too short");
   AST_PERIOD: assert property ($rose(pw_out) |->
      gap_ff inside {[FRAMEP-3:FRAMEP+2]}) else $error("frame period off");
   AST_ALIVE: assert property (gap_ff <= FRAMEP + 2)
      else $error("pulses stopped");
   AST_FIRST: assert property ($rose(rst_b) |-> !pw_out[*8])
      else $error("pulse right after reset");
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench joining sensor and decoder ends
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import enc_pkg::*;
   localparam int FR = 2000; // short frame keeps the run brief
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic s_rst_b = 1'b0;
   logic seed_req = 1'b0;
   logic [ANGLE_W-1:0] angle = '0;
   logic [31:0] quad_count;
   logic [ANGLE_W-1:0] abs_angle;
   logic abs_valid;
   logic sensor_lost;
   logic seeded;
   int mismatches = 0;
   int n_tests = 0;
   int cyc = 0;
   enc_link_if link ();
   enc_sensor #(.FRAME_CYCLES(FR)) enc_sensor_i (.clock(clock),
      .rst_b(s_rst_b), .angle(angle), .link(link));
   enc_decoder #(.LOSS_CYCLES(3 * FR)) enc_decoder_i (.clock(clock),
      .rst_b(rst_b), .seed_req(seed_req), .link(link),
      .quad_count(quad_count), .abs_angle(abs_angle),
      .abs_valid(abs_valid), .sensor_lost(sensor_lost), .seeded(seeded));
   enc_link_props #(.FRAMEP(FR)) enc_link_props_i (.clock(clock),
      .rst_b(s_rst_b), .quad_a(link.quad_a), .quad_b(link.quad_b),
      .pw_out(link.pw_out));
   always #20 clock = ~clock;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // sample mid-cycle so edge updates have landed
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   // wait for the next whole pulse, then let the decode settle
   task automatic pulse_end();
      int k;
      k = 0;
      while (link.pw_out !== 1'b1 && k < 4 * FR) begin
         tick(1);
         k++;
      end
      while (link.pw_out === 1'b1 && k < 4 * FR) begin
         tick(1);
         k++;
      end
      tick(2);
   endtask
   // hang guard: several frames beyond the planned sequence
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      s_rst_b <= 1'b1;
      tick(1);
      check(quad_count, 0, "count after reset");
      check(abs_valid, 0, "valid after reset");
      @(posedge clock) angle <= 10'h005;
      tick(12);
      check(quad_count, 5, "forward count");
      @(posedge clock) angle <= 10'h002;
      tick(12);
      check(quad_count, 2, "reverse count");
      $display("test quadrature done");
      // angle 20 leaves both phases low, so a sensor reset moves no line
      @(posedge clock) angle <= 10'h014;
      pulse_end();
      pulse_end();
      check(abs_angle, 20, "absolute angle");
      check(abs_valid, 1, "absolute valid");
      check(quad_count, 20, "count beside pulse");
      $display("test pulse width done");
      // shaft moves while the sensor is down: its new zero is angle 12
      @(posedge clock) s_rst_b <= 1'b0;
      angle <= 10'h00c;
      tick(3 * FR + 10);
      check(sensor_lost, 1, "loss flagged");
      @(posedge clock) s_rst_b <= 1'b1;
      pulse_end();
      check(sensor_lost, 0, "loss cleared");
      check(quad_count, 20, "count kept over restart");
      check(abs_angle, 12, "angle after restart");
      $display("test loss done");
      @(posedge clock) seed_req <= 1'b1;
      @(posedge clock) seed_req <= 1'b0;
      pulse_end();
      check(seeded, 1, "seed done");
      check(quad_count, 12, "seeded count");
      $display("test seed done");
      complete_run();
   end
endmodule
`default_nettype wire
